// *** rtl/stmpm_timer.sv ***
// Purpose: standard timer with compare-match output, timer/counter and edge-aligned pwm modes
// Assumes: timer clock is i_clk; registers reached over a zero-wait APB slave
// Notes: instance index 0 gives the 10-bit variant, index 1 the 16-bit one
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "stmpm_defines.svh"

// Functional notes
// - mode 00 is compare-match output mode
// - clear-select low: clear on p, both flags
// - clear-select high: clear on a, a flag only
// - a zero: overflow at maximum, no a flag
// - pin changes only on comparator a match
// - pin action: none, low, high, toggle
// - run rising edge loads initial pin level
// - mode 11 counts like mode 00, pin free
// - mode 10 pwm, swap picks period and duty
// - pwm raises a and p flags on matches
// - pwm polarity, force levels, invert select
// - narrow, swap 0: period p times 128
// - narrow, swap 1: period a, duty p times 128
// - wide, swap 0: period p times 256
// - wide, swap 1: period a, duty p times 256
// - duty at or above period holds active
// - pwm keeps running while pin forced
// - index 0 ten bits, index 1 sixteen
// - invert bit flips the driven pin level
module stmpm_timer #(
  parameter int TIMER_INDEX = 0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`STMPM_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_pin,
  output logic o_pin_oe,
  output logic o_match_a_flag,
  output logic o_match_p_flag
);

  // counter and compare widths follow the variant
  localparam int W = (TIMER_INDEX == 0) ? `STMPM_W_NARROW : `STMPM_W_WIDE;
  localparam int PW = (TIMER_INDEX == 0) ? `STMPM_PW_NARROW : `STMPM_PW_WIDE;
  localparam int LOW = W - PW;

  if (TIMER_INDEX != 0 && TIMER_INDEX != 1) begin : g_bad_index
    $error("stmpm_timer: TIMER_INDEX must be 0 or 1");
  end

  typedef struct packed {
    logic run;
    logic run_d1;
    logic [1:0] mode;
    logic [1:0] pin_action;
    logic init_level;
    logic invert;
    logic swap;
    logic clear_sel;
    logic [W-1:0] cmp_a;
    logic [PW-1:0] cmp_p;
    logic flag_a;
    logic flag_p;
    logic [31:0] prdata;
  } stmpm_top_state_t;

  stmpm_top_state_t st_q;
  stmpm_top_state_t st_d;

  // register map, one aligned word each, reserved bits read zero:
  //   ctrl0  bit 0 run bit; a rising edge restarts count and pin
  //   ctrl1  bits 7:6 mode, 5:4 pin action, 3 initial level,
  //          bit 2 polarity invert, 1 duty/period swap, 0 clear select
  //   count  read only, value seen at the setup edge
  //   cmpa   low W bits, compare a value
  //   cmpp   low PW bits, compared with the top PW counter bits
  //   status bit 0 match a flag, bit 1 match p flag, write one to clear
  // modes: 00 compare output, 10 pwm, 11 timer, 01 runs like 11
  // hazards kept by software, not checked here:
  //   a zero compare a value in compare mode gives no a flag
  //   mode, pin action and swap change only while stopped
  // the slave never stalls: pready is tied high, and an unmapped
  // address answers with pslverr and zero read data

  // bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_word;

  // timer core
  logic restart;
  logic is_pwm;
  logic a_nonzero;
  logic [W:0] full_range;
  logic [W:0] a_full;
  logic [W:0] p_full;
  logic [W:0] a_tgt;
  logic [W:0] p_tgt;
  logic clr_on_a;
  logic clr_on_p;
  logic [W-1:0] count;
  logic a_hit;
  logic p_hit;
  logic a_event;
  logic p_event;
  logic [W:0] duty;
  logic [W:0] period;
  logic pwm_on;
  stmpm_pkg::stmpm_drive_t drive;

  assign setup_ph = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign wr_en = access_ph && i_pwrite && addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    unique case (i_paddr)
      `STMPM_ADDR_CTRL0,
      `STMPM_ADDR_CTRL1,
      `STMPM_ADDR_COUNT,
      `STMPM_ADDR_CMPA,
      `STMPM_ADDR_CMPP,
      `STMPM_ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (i_paddr)
      `STMPM_ADDR_CTRL0: begin
        rd_word[`STMPM_CTRL0_RUN] = st_q.run;
      end
      `STMPM_ADDR_CTRL1: begin
        rd_word[`STMPM_CTRL1_MODE_HI:`STMPM_CTRL1_MODE_LO] = st_q.mode;
        rd_word[`STMPM_CTRL1_PIN_HI:`STMPM_CTRL1_PIN_LO] = st_q.pin_action;
        rd_word[`STMPM_CTRL1_INIT] = st_q.init_level;
        rd_word[`STMPM_CTRL1_INV] = st_q.invert;
        rd_word[`STMPM_CTRL1_SWAP] = st_q.swap;
        rd_word[`STMPM_CTRL1_CLRSEL] = st_q.clear_sel;
      end
      `STMPM_ADDR_COUNT: begin
        rd_word[W-1:0] = count;
      end
      `STMPM_ADDR_CMPA: begin
        rd_word[W-1:0] = st_q.cmp_a;
      end
      `STMPM_ADDR_CMPP: begin
        rd_word[PW-1:0] = st_q.cmp_p;
      end
      `STMPM_ADDR_STATUS: begin
        rd_word[`STMPM_STATUS_FLAG_A] = st_q.flag_a;
        rd_word[`STMPM_STATUS_FLAG_P] = st_q.flag_p;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // run bit rising edge restarts counter and reloads the pin
  assign restart = st_q.run && !st_q.run_d1;
  assign is_pwm = (st_q.mode == `STMPM_MODE_PWM);
  assign a_nonzero = (st_q.cmp_a != '0);

  // a zero compare value stands for the full counter range
  assign full_range = {1'b1, {W{1'b0}}};
  assign a_full = a_nonzero ? {1'b0, st_q.cmp_a} : full_range;
  // p is compared with the top counter bits, so it steps in 2**LOW counts
  assign p_full = (st_q.cmp_p == '0) ? full_range : {1'b0, st_q.cmp_p, {LOW{1'b0}}};

  assign a_tgt = a_full;
  assign p_tgt = p_full;

  always_comb begin
    clr_on_a = 1'b0;
    clr_on_p = 1'b0;
    if (is_pwm) begin
      // clear-select is ignored; the period comparator clears
      clr_on_a = st_q.swap;
      clr_on_p = !st_q.swap;
    end else begin
      clr_on_a = st_q.clear_sel && a_nonzero;
      clr_on_p = !st_q.clear_sel;
    end
  end

  stmpm_counter #(
    .W(W)
  ) u_counter (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(st_q.run),
    .i_restart(restart),
    .i_a_tgt(a_tgt),
    .i_p_tgt(p_tgt),
    .i_clr_on_a(clr_on_a),
    .i_clr_on_p(clr_on_p),
    .o_count(count),
    .o_a_hit(a_hit),
    .o_p_hit(p_hit)
  );

  // flag events; a zero a value never raises the a flag
  always_comb begin
    a_event = a_hit && a_nonzero;
    p_event = 1'b0;
    if (is_pwm) begin
      p_event = p_hit;
    end else begin
      p_event = p_hit && !st_q.clear_sel;
    end
  end

  // edge-aligned pwm: active from counter clear until duty is reached
  assign period = st_q.swap ? a_full : p_full;
  assign duty = st_q.swap ? p_full : {1'b0, st_q.cmp_a};
  assign pwm_on = (duty >= period) || ({1'b0, count} < duty);

  // pin drive class per mode; timer mode leaves the pin free
  always_comb begin
    unique case (st_q.mode)
      `STMPM_MODE_CMP: begin
        drive = stmpm_pkg::STMPM_DRV_CMP;
      end
      `STMPM_MODE_PWM: begin
        drive = stmpm_pkg::STMPM_DRV_PWM;
      end
      `STMPM_MODE_TMR: begin
        drive = stmpm_pkg::STMPM_DRV_OFF;
      end
      `STMPM_MODE_CAPT: begin
        // capture is not built: counts like timer mode, pin free
        drive = stmpm_pkg::STMPM_DRV_OFF;
      end
    endcase
  end

  stmpm_pin u_pin (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_drive(drive),
    .i_restart(restart),
    .i_a_event(a_event),
    .i_pin_action(st_q.pin_action),
    .i_init_level(st_q.init_level),
    .i_invert(st_q.invert),
    .i_pwm_on(pwm_on),
    .o_pin(o_pin),
    .o_pin_oe(o_pin_oe)
  );

  // register file and flags
  // read data is taken at the setup edge, so a read of count
  // returns the value one cycle before the access edge
  // a flag write-one-to-clear loses against a match in the same
  // cycle, so no event is ever dropped by software polling
  always_comb begin
    st_d = st_q;
    st_d.run_d1 = st_q.run;
    if (setup_ph) begin
      st_d.prdata = rd_word;
    end
    if (wr_en) begin
      unique case (i_paddr)
        `STMPM_ADDR_CTRL0: begin
          st_d.run = i_pwdata[`STMPM_CTRL0_RUN];
        end
        `STMPM_ADDR_CTRL1: begin
          st_d.mode = i_pwdata[`STMPM_CTRL1_MODE_HI:`STMPM_CTRL1_MODE_LO];
          st_d.pin_action = i_pwdata[`STMPM_CTRL1_PIN_HI:`STMPM_CTRL1_PIN_LO];
          st_d.init_level = i_pwdata[`STMPM_CTRL1_INIT];
          st_d.invert = i_pwdata[`STMPM_CTRL1_INV];
          st_d.swap = i_pwdata[`STMPM_CTRL1_SWAP];
          st_d.clear_sel = i_pwdata[`STMPM_CTRL1_CLRSEL];
        end
        `STMPM_ADDR_CMPA: begin
          st_d.cmp_a = i_pwdata[W-1:0];
        end
        `STMPM_ADDR_CMPP: begin
          st_d.cmp_p = i_pwdata[PW-1:0];
        end
        `STMPM_ADDR_STATUS: begin
          // write one to clear
          if (i_pwdata[`STMPM_STATUS_FLAG_A]) begin
            st_d.flag_a = 1'b0;
          end
          if (i_pwdata[`STMPM_STATUS_FLAG_P]) begin
            st_d.flag_p = 1'b0;
          end
        end
        default: begin
          st_d.run = st_q.run;
        end
      endcase
    end
    // a match in the clearing cycle still sets its flag
    if (a_event) begin
      st_d.flag_a = 1'b1;
    end
    if (p_event) begin
      st_d.flag_p = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_prdata = st_q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = access_ph && !addr_ok;
  assign o_match_a_flag = st_q.flag_a;
  assign o_match_p_flag = st_q.flag_p;

endmodule : stmpm_timer
`default_nettype wire

// *** rtl/stmpm_defines.svh ***
// Purpose: register offsets, field positions, reset values and codes of the timer
// Assumes: 8-bit APB byte address, one aligned 32-bit word per register
// Notes: definitions only
`ifndef STMPM_DEFINES_SVH
`define STMPM_DEFINES_SVH

`define STMPM_ADDR_W 8
`define STMPM_ADDR_CTRL0 8'h00
`define STMPM_ADDR_CTRL1 8'h04
`define STMPM_ADDR_COUNT 8'h08
`define STMPM_ADDR_CMPA 8'h0c
`define STMPM_ADDR_CMPP 8'h10
`define STMPM_ADDR_STATUS 8'h14

`define STMPM_CTRL0_RUN 0
`define STMPM_CTRL1_MODE_HI 7
`define STMPM_CTRL1_MODE_LO 6
`define STMPM_CTRL1_PIN_HI 5
`define STMPM_CTRL1_PIN_LO 4
`define STMPM_CTRL1_INIT 3
`define STMPM_CTRL1_INV 2
`define STMPM_CTRL1_SWAP 1
`define STMPM_CTRL1_CLRSEL 0
`define STMPM_STATUS_FLAG_A 0
`define STMPM_STATUS_FLAG_P 1

`define STMPM_CTRL1_RESET 8'h00
`define STMPM_CMP_RESET 16'h0000

`define STMPM_MODE_CMP 2'b00
`define STMPM_MODE_CAPT 2'b01
`define STMPM_MODE_PWM 2'b10
`define STMPM_MODE_TMR 2'b11

`define STMPM_PIN_NONE 2'b00
`define STMPM_PIN_LOW 2'b01
`define STMPM_PIN_HIGH 2'b10
`define STMPM_PIN_TOGGLE 2'b11
`define STMPM_PWM_INACTIVE 2'b00
`define STMPM_PWM_ACTIVE 2'b01
`define STMPM_PWM_WAVE 2'b10

`define STMPM_W_NARROW 10
`define STMPM_W_WIDE 16
`define STMPM_PW_NARROW 3
`define STMPM_PW_WIDE 8

`endif

// *** rtl/stmpm_pkg.sv ***
// Purpose: shared types of the timer
// Assumes: nothing
// Notes: pin drive class chosen by the timer top
package stmpm_pkg;

  typedef enum logic [1:0] {
    STMPM_DRV_OFF,
    STMPM_DRV_CMP,
    STMPM_DRV_PWM
  } stmpm_drive_t;

endpackage : stmpm_pkg

// *** rtl/stmpm_counter.sv ***
// Purpose: count-up counter with comparators a and p
// Assumes: targets are given as "period length", 2**W meaning full range
// Notes: a hit is flagged on the last count before the target value
`timescale 1ns/100ps
`default_nettype none
module stmpm_counter #(
  parameter int W = 10
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [W:0] i_a_tgt,
  input wire logic [W:0] i_p_tgt,
  input wire logic i_clr_on_a,
  input wire logic i_clr_on_p,
  output logic [W-1:0] o_count,
  output logic o_a_hit,
  output logic o_p_hit
);

  typedef struct packed {
    logic [W-1:0] count;
  } stmpm_cnt_state_t;

  stmpm_cnt_state_t st_q;
  stmpm_cnt_state_t st_d;
  logic [W:0] count_p1;

  assign count_p1 = {1'b0, st_q.count} + {{W{1'b0}}, 1'b1};
  assign o_a_hit = i_run && !i_restart && (count_p1 == i_a_tgt);
  assign o_p_hit = i_run && !i_restart && (count_p1 == i_p_tgt);
  assign o_count = st_q.count;

  always_comb begin
    st_d = st_q;
    if (i_restart) begin
      st_d.count = '0;
    end else if (i_run) begin
      if ((o_a_hit && i_clr_on_a) || (o_p_hit && i_clr_on_p)) begin
        st_d.count = '0;
      end else begin
        st_d.count = count_p1[W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : stmpm_counter
`default_nettype wire

// *** rtl/stmpm_pin.sv ***
// Purpose: output pin of the timer in compare and pwm modes
// Assumes: events are one-cycle pulses from the timer top
// Notes: pin and enable are registered, one cycle behind their cause
`timescale 1ns/100ps
`default_nettype none
`include "stmpm_defines.svh"
module stmpm_pin (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire stmpm_pkg::stmpm_drive_t i_drive,
  input wire logic i_restart,
  input wire logic i_a_event,
  input wire logic [1:0] i_pin_action,
  input wire logic i_init_level,
  input wire logic i_invert,
  input wire logic i_pwm_on,
  output logic o_pin,
  output logic o_pin_oe
);

  typedef struct packed {
    logic level;
    logic pin;
    logic oe;
  } stmpm_pin_state_t;

  stmpm_pin_state_t st_q;
  stmpm_pin_state_t st_d;
  logic pwm_act;

  always_comb begin
    st_d = st_q;
    pwm_act = 1'b0;
    if (i_restart) begin
      st_d.level = i_init_level;
    end else if (i_drive == stmpm_pkg::STMPM_DRV_CMP && i_a_event) begin
      unique case (i_pin_action)
        `STMPM_PIN_NONE: st_d.level = st_q.level;
        `STMPM_PIN_LOW: st_d.level = 1'b0;
        `STMPM_PIN_HIGH: st_d.level = 1'b1;
        `STMPM_PIN_TOGGLE: st_d.level = ~st_q.level;
      endcase
    end
    // pwm waveform keeps running whatever the pin action forces
    unique case (i_pin_action)
      `STMPM_PWM_INACTIVE: pwm_act = 1'b0;
      `STMPM_PWM_ACTIVE: pwm_act = 1'b1;
      `STMPM_PWM_WAVE: pwm_act = i_pwm_on;
      default: pwm_act = 1'b0;
    endcase
    unique case (i_drive)
      stmpm_pkg::STMPM_DRV_CMP: begin
        st_d.pin = st_d.level ^ i_invert;
        st_d.oe = 1'b1;
      end
      stmpm_pkg::STMPM_DRV_PWM: begin
        st_d.pin = (pwm_act ? i_init_level : ~i_init_level) ^ i_invert;
        st_d.oe = 1'b1;
      end
      default: begin
        st_d.pin = 1'b0;
        st_d.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pin = st_q.pin;
  assign o_pin_oe = st_q.oe;

endmodule : stmpm_pin
`default_nettype wire

// *** bench/stmpm_timer_sva.sv ***
// Purpose: port checks of the timer
// Assumes: zero-wait apb slave
// Notes: shadows follow register writes
`timescale 1ns/100ps
`default_nettype none
`include "stmpm_defines.svh"
module stmpm_timer_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`STMPM_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_pin,
  input wire logic o_pin_oe,
  input wire logic o_match_a_flag,
  input wire logic o_match_p_flag
);
  logic wr_c;
  logic st_c;
  logic [1:0] mode_q;
  logic run_q;
  logic clr_q;
  logic az_q;
  assign wr_c = i_psel && i_penable && i_pwrite;
  assign st_c = wr_c && i_paddr == `STMPM_ADDR_STATUS;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= 2'b00;
      run_q <= 1'b0;
      clr_q <= 1'b0;
      az_q <= 1'b1;
    end else if (wr_c) begin
      if (i_paddr == `STMPM_ADDR_CTRL0) begin
        run_q <= i_pwdata[0];
      end
      if (i_paddr == `STMPM_ADDR_CTRL1) begin
        mode_q <= i_pwdata[7:6];
        clr_q <= i_pwdata[0];
      end
      if (i_paddr == `STMPM_ADDR_CMPA) begin
        az_q <= i_pwdata[15:0] == 16'h0000;
      end
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_ready_always: assert property (o_pready) else $error("pready low");
  a_err_unmapped: assert property (i_psel && i_penable |->
    o_pslverr == (i_paddr > `STMPM_ADDR_STATUS || i_paddr[1:0] != 2'b00)) else $error("pslverr wrong");
  a_a_flag_zero: assert property ($rose(o_match_a_flag) |-> !$past(az_q)) else $error("a flag with a zero");
  a_p_flag_clrsel: assert property ($rose(o_match_p_flag) |->
    !$past(clr_q) || $past(mode_q) == 2'b10) else $error("p flag while clearing on a");
  a_a_clear_w1c: assert property ($fell(o_match_a_flag) |-> $past(st_c && i_pwdata[0])) else $error("a flag lost");
  a_p_clear_w1c: assert property ($fell(o_match_p_flag) |-> $past(st_c && i_pwdata[1])) else $error("p flag lost");
  a_pin_on_match: assert property ($changed(o_pin) && mode_q == 2'b00 && run_q && $past(run_q, 3)
    |-> o_match_a_flag) else $error("pin moved without a match");
  a_timer_pin_free: assert property (mode_q[0] && $past(mode_q[0]) |-> !o_pin_oe && !o_pin)
    else $error("pin driven in timer mode");
endmodule : stmpm_timer_sva
`default_nettype wire

// *** bench/stmpm_timer_bench.sv ***
// Purpose: self-checking bench of the timer
// Assumes: 10-bit variant, zero-wait apb
// Notes: random compare values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`include "stmpm_defines.svh"
module stmpm_timer_bench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [`STMPM_ADDR_W-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_pin, o_pin_oe, o_match_a_flag, o_match_p_flag;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er, il, iv;
  int a, k, n, per;
  int act_t[7] = '{2, 2, 2, 2, 2, 0, 1};
  int sw_t[7] = '{0, 0, 1, 0, 1, 0, 0};
  int p_t[7] = '{1, 1, 1, 0, 0, 1, 1};
  int a_t[7] = '{5, 200, 300, 500, 40, 60, 60};
  always #2 i_clk = ~i_clk;
  stmpm_timer #(.TIMER_INDEX(0)) u_stmpm_timer (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pin, .o_pin_oe, .o_match_a_flag, .o_match_p_flag);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic cnt_act(input int c, input logic lv);
    n = 0;
    repeat (c) begin
      @(negedge i_clk);
      n += int'(o_pin === lv);
    end
    @(posedge i_clk);
  endtask : cnt_act
  task automatic setup(input int av, input logic [31:0] c1);
    bus(1'b1, `STMPM_ADDR_CTRL0, 32'h0);
    bus(1'b1, `STMPM_ADDR_STATUS, 32'h3);
    bus(1'b1, `STMPM_ADDR_CMPA, 32'(av));
    bus(1'b1, `STMPM_ADDR_CTRL1, c1);
    bus(1'b1, `STMPM_ADDR_CTRL0, 32'h1);
  endtask : setup
  function automatic logic cmp_pin(input int act, input logic i, input logic v);
    case (act)
      0: return i ^ v;
      1: return v;
      2: return ~v;
      default: return ~i ^ v;
    endcase
  endfunction : cmp_pin
  function automatic int pwm_on(input int act, input int sw, input int p, input int av, input int pr);
    int du;
    du = sw ? (p == 0 ? 1024 : p * 128) : av;
    if (act != 2) du = act * pr;
    return du < pr ? du : pr;
  endfunction : pwm_on
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(54785));
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 7; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0);
      chk("reset read", 32'h0, rd);
      chk("slave error", 32'(k == 6), 32'(er));
    end
    bus(1'b1, `STMPM_ADDR_CMPP, 32'h1);
    a = 200 + $urandom_range(500);
    for (k = 0; k < 4; k++) begin
      il = 1'($urandom);
      iv = 1'($urandom);
      setup(a, {24'h0, 2'b00, 2'(k), il, iv, 2'b01});
      repeat (a - 1) @(posedge i_clk);
      @(negedge i_clk);
      chk("pin at start", 32'(il ^ iv), 32'(o_pin));
      chk("flag early", 32'h0, 32'(o_match_a_flag));
      @(negedge i_clk);
      chk("pin at match", 32'(cmp_pin(k, il, iv)), 32'(o_pin));
      chk("flags", 32'h1, 32'({o_match_p_flag, o_match_a_flag}));
      chk("pin enable", 32'h1, 32'(o_pin_oe));
      @(posedge i_clk);
    end
    setup(10 + $urandom_range(90), 32'h30);
    repeat (130) @(posedge i_clk);
    @(negedge i_clk);
    chk("pin after p", 32'h1, 32'(o_pin));
    @(posedge i_clk);
    bus(1'b0, `STMPM_ADDR_STATUS, 32'h0);
    chk("both flags", 32'h3, rd);
    setup(0, 32'hc1);
    repeat (1100) @(posedge i_clk);
    bus(1'b1, `STMPM_ADDR_CTRL0, 32'h0);
    bus(1'b0, `STMPM_ADDR_STATUS, 32'h0);
    chk("no a flag", 32'h0, rd);
    bus(1'b0, `STMPM_ADDR_COUNT, 32'h0);
    chk("count", 32'd78, rd);
    a_t[0] = 1 + $urandom_range(126);
    for (k = 0; k < 7; k++) begin
      il = 1'($urandom);
      iv = 1'($urandom);
      bus(1'b1, `STMPM_ADDR_CTRL0, 32'h0);
      bus(1'b1, `STMPM_ADDR_CMPP, 32'(p_t[k]));
      setup(a_t[k], {24'h0, 2'b10, 2'(act_t[k]), il, iv, 1'(sw_t[k]), 1'($urandom)});
      per = sw_t[k] ? a_t[k] : (p_t[k] == 0 ? 1024 : p_t[k] * 128);
      repeat (8) @(posedge i_clk);
      cnt_act(per, il ^ iv);
      chk("duty", 32'(pwm_on(act_t[k], sw_t[k], p_t[k], a_t[k], per)), 32'(n));
      chk("pwm enable", 32'h1, 32'(o_pin_oe));
      if (k == 0 || k == 2) chk("pwm flags", 32'h3, 32'({o_match_p_flag, o_match_a_flag}));
    end
    complete_run();
  end
endmodule : stmpm_timer_bench
bind stmpm_timer stmpm_timer_sva u_stmpm_timer_sva (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pin, .o_pin_oe, .o_match_a_flag, .o_match_p_flag);
`default_nettype wire
